// ==== rtl/hdg_pkg.sv ====
/*
 Constants and types for the host decode and interrupt steering glue.
 Assumes a single reference clock and ISA-style 10-bit I/O addressing.
*/
// Contract
// - Disk enable low only when disk function enabled and a disk register is addressed.
// - First disk select asserts for the eight-address control block.
// - Second disk select asserts for the alternate status register location.
// - Disk decoder never responds to addresses 377 or 3F7.
// - General decode low inside configured block of one, eight or sixteen bytes.
// - Game select low only on configured address match with AEN low.
// - External interrupt input routed to the selected IRQ output A through H.
// - In EPP or ECP mode IRQ outputs pulse low then release, open-drain.
// - In EPP mode IOCHRDY pulled low to stretch; host holds command until release.
// - Power-good low ignores inputs, floats outputs, keeps registers.
// - Ring indicate and serial interrupt stay functional regardless of power-good.
// - Alternate floppy mode samples second-drive sense for status register A.
// - Second-drive sense reported active low as bit 6 of status register A.
`default_nettype none
package hdg_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          IRQ_N         = 8;
    localparam logic [9:0]  DISK_EXCL_LO  = 10'h377;
    localparam logic [9:0]  DISK_EXCL_HI  = 10'h3F7;
    localparam logic [9:0]  DISK_ALT_OFS  = 10'h006;
    localparam int          SECOND_DRIVE_STAT_BIT = 6;
    localparam int          CLK_HZ        = 25000000;
    // IRQ pulse width in ns and derived cycles
    localparam int          IRQ_PULSE_NS  = 200;
    localparam int          IRQ_PULSE_CYC = (IRQ_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Size codes for the general block decode
    typedef enum logic [1:0] {HDG_SZ1, HDG_SZ8, HDG_SZ16} hdg_size_t;
endpackage
`default_nettype wire

// ==== rtl/hdg_sync.sv ====
/*
 Three-stage input synchroniser; change accepted when stages two and three agree.
 Assumes asynchronous active-low reset already released synchronously.
*/
`default_nettype none
module hdg_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output var  logic q_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Shift chain; only s2 reads s1
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end
        else
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Filtered output holds until two and three agree
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q_o <= RST_VAL;
        else if (s2_reg == s3_reg)
            q_o <= s3_reg;
    end
endmodule
`default_nettype wire

// ==== rtl/hdg_glue.sv ====
/*
 Host decode, interrupt steering, IOCHRDY stretch and standby glue.
 Assumes configuration inputs static during operation and host address from ISA pins.
 Decode outputs are combinational from the live address; the host samples them.
*/
`default_nettype none
module hdg_glue
    import hdg_pkg::*;
#(
    parameter int PULSE_CYC = IRQ_PULSE_CYC
)
(
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] sa_i,
    input  wire logic              aen_i,
    input  wire logic              disk_en_i,
    input  wire logic [ADDR_W-1:0] disk_base_i,
    input  wire logic [ADDR_W-1:0] gp_base_i,
    input  wire logic [1:0]        gp_size_i,
    input  wire logic              gp_en_i,
    input  wire logic [ADDR_W-1:0] game_base_i,
    input  wire logic              game_en_i,
    input  wire logic [2:0]        irq_sel_i,
    input  wire logic              irq_route_en_i,
    input  wire logic              epp_mode_i,
    input  wire logic              ecp_mode_i,
    input  wire logic              epp_busy_i,
    input  wire logic              alt_fdc_mode_i,
    input  wire logic              ext_irq_in_i,
    input  wire logic              power_good_in_i,
    input  wire logic              second_drive_sense_i,
    input  wire logic              ring_ind_n_i,
    input  wire logic              ser_irq_i,
    output logic                   disk_if_enable_n_o,
    output logic                   disk_ctrl_block_sel_n_o,
    output logic                   disk_alt_status_sel_n_o,
    output logic                   gp_block_decode_n_o,
    output logic                   gp_block_decode_oe_n_o,
    output logic                   game_port_sel_n_o,
    output logic [IRQ_N-1:0]       irq_o,
    output logic [IRQ_N-1:0]       irq_oe_n_o,
    output logic                   iochrdy_o,
    output logic                   iochrdy_oe_n_o,
    output logic                   outputs_float_o,
    output logic                   second_drive_stat_n_o,
    output logic                   ring_ind_n_o,
    output logic                   ser_irq_o
);
    // Pulse counter is eight bits wide; a zero-length pulse would never reach the pin
    if (PULSE_CYC < 1 || PULSE_CYC > 255)
    begin : g_bad_pulse
        $error("PULSE_CYC out of range");
    end

    logic       rst_a_reg;
    logic       rst_n;
    logic       ext_irq_s;
    logic       pg_s;
    logic       second_drive_s;
    logic       pg_ok;
    logic       disk_ctrl_hit;
    logic       disk_alt_hit;
    logic       disk_excl;
    logic       gp_hit;
    logic       game_hit;
    logic       shared_mode;
    logic       irq_prev_reg;
    logic [7:0] pulse_cnt_reg;
    logic       second_drive_n_reg;

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_a_reg <= 1'b0;
            rst_n     <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_n     <= rst_a_reg;
        end
    end

    hdg_sync #(.RST_VAL(1'b0)) u_irq_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .d_i       (ext_irq_in_i),
        .q_o       (ext_irq_s)
    );

    hdg_sync #(.RST_VAL(1'b0)) u_pg_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .d_i       (power_good_in_i),
        .q_o       (pg_s)
    );

    hdg_sync #(.RST_VAL(1'b1)) u_second_drive_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .d_i       (second_drive_sense_i),
        .q_o       (second_drive_s)
    );

    // Address decode is combinational; qualified by AEN low for non-DMA
    assign pg_ok        = pg_s;
    assign disk_excl    = (sa_i == DISK_EXCL_LO) || (sa_i == DISK_EXCL_HI);
    assign disk_ctrl_hit = disk_en_i && !aen_i && !disk_excl
                         && (sa_i[ADDR_W-1:3] == disk_base_i[ADDR_W-1:3]);
    assign disk_alt_hit = disk_en_i && !aen_i && !disk_excl
                        && (sa_i == (disk_base_i | DISK_ALT_OFS));
    assign game_hit     = game_en_i && !aen_i && (sa_i == game_base_i);

    // Block size mask; 16 bytes widest, unknown code treated as one byte
    always_comb
    begin
        gp_hit = 1'b0;
        if (gp_en_i && !aen_i)
        begin
            unique case (gp_size_i)
                HDG_SZ8:  gp_hit = sa_i[ADDR_W-1:3] == gp_base_i[ADDR_W-1:3];
                HDG_SZ16: gp_hit = sa_i[ADDR_W-1:4] == gp_base_i[ADDR_W-1:4];
                default:  gp_hit = sa_i == gp_base_i;
            endcase
        end
    end

    // Decode outputs; parked inactive in standby since the pins are floated
    assign disk_ctrl_block_sel_n_o = !(pg_ok && disk_ctrl_hit);
    assign disk_alt_status_sel_n_o = !(pg_ok && disk_alt_hit);
    assign disk_if_enable_n_o      = !(pg_ok && (disk_ctrl_hit || disk_alt_hit));
    assign game_port_sel_n_o       = !(pg_ok && game_hit);
    assign gp_block_decode_n_o     = 1'b0;
    assign gp_block_decode_oe_n_o  = !(pg_ok && gp_hit);
    assign outputs_float_o         = !pg_ok;

    assign shared_mode = epp_mode_i || ecp_mode_i;

    // Rising request edge starts a fixed-width low pulse in shared mode
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_prev_reg  <= 1'b0;
            pulse_cnt_reg <= 8'h00;
        end
        else if (pg_ok)
        begin
            irq_prev_reg <= ext_irq_s;
            if (ext_irq_s && !irq_prev_reg && shared_mode)
                pulse_cnt_reg <= 8'(PULSE_CYC);
            else if (pulse_cnt_reg != 8'h00)
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
        end
    end

    // Steering: only the selected line carries the request
    always_comb
    begin
        irq_o      = '0;
        irq_oe_n_o = '1;
        if (pg_ok && irq_route_en_i)
        begin
            if (shared_mode)
                irq_oe_n_o[irq_sel_i] = (pulse_cnt_reg == 8'h00);
            else
            begin
                irq_o[irq_sel_i]      = ext_irq_s;
                irq_oe_n_o[irq_sel_i] = 1'b0;
            end
        end
    end

    // Wait stretch; release lets the external pull-up on the host board raise the line
    assign iochrdy_o      = 1'b0;
    assign iochrdy_oe_n_o = !(pg_ok && epp_mode_i && epp_busy_i);

    // Second-drive sense captured only in alternate mode; held in standby
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            second_drive_n_reg <= 1'b1;
        else if (pg_ok && alt_fdc_mode_i)
            second_drive_n_reg <= second_drive_s;
    end
    assign second_drive_stat_n_o = second_drive_n_reg;

    // Serial wake paths bypass power-good gating
    assign ring_ind_n_o = ring_ind_n_i;
    assign ser_irq_o    = ser_irq_i;

    chk_disk_excl: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        disk_excl |-> (disk_if_enable_n_o && disk_ctrl_block_sel_n_o && disk_alt_status_sel_n_o))
        else $error("disk decode hit excluded address");
    chk_disk_enable: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !disk_if_enable_n_o |-> (disk_en_i && pg_ok))
        else $error("disk enable without function enabled");
    chk_alt_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !disk_alt_status_sel_n_o |-> (sa_i[2:0] == 3'h6) && !disk_if_enable_n_o)
        else $error("alt status select wrong");
    chk_game_aen: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        aen_i |-> game_port_sel_n_o)
        else $error("game select during DMA");
    chk_float_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !pg_ok |-> (&irq_oe_n_o && iochrdy_oe_n_o && gp_block_decode_oe_n_o))
        else $error("drive during standby");
    sequence s_req_rise;
        $rose(ext_irq_s) && shared_mode && pg_ok && irq_route_en_i;
    endsequence
    chk_pulse_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (s_req_rise ##1 pg_ok) |-> (pulse_cnt_reg == 8'(PULSE_CYC)))
        else $error("irq pulse length wrong");
    chk_irq_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (pg_ok && irq_route_en_i && !shared_mode) |-> (irq_o == (ext_irq_s << irq_sel_i)))
        else $error("irq routed to wrong line");
    chk_drive_sense_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !alt_fdc_mode_i |=> $stable(second_drive_stat_n_o))
        else $error("drive sense changed outside alt mode");
    chk_rdy_epp: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !iochrdy_oe_n_o |-> epp_mode_i)
        else $error("IOCHRDY stretched outside EPP");
endmodule
`default_nettype wire

// ==== tb/hdg_host_model.sv ====
/*
 Host bus side model: resolves the shared open-drain lines.
 Assumes pull-ups on every shared line, as on the host board.
*/
`default_nettype none
module hdg_host_model
(
    input  wire logic [7:0] irq_i,
    input  wire logic [7:0] irq_oe_n_i,
    input  wire logic       chrdy_i,
    input  wire logic       chrdy_oe_n_i,
    input  wire logic       gp_i,
    input  wire logic       gp_oe_n_i,
    output logic      [7:0] irq_line_o,
    output logic            chrdy_line_o,
    output logic            gp_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released lines float up to the pull-up, never keep the last value
    assign irq_line_o   = irq_i | irq_oe_n_i;
    assign chrdy_line_o = chrdy_i | chrdy_oe_n_i;
    assign gp_line_o    = gp_i | gp_oe_n_i;
endmodule
`default_nettype wire

// ==== tb/host_decode_irq_steering_glue_bench.sv ====
/*
 Self-checking bench: random decodes, IRQ steering, IOCHRDY, standby, drive sense.
 Assumes the host model resolves the open-drain lines.
*/
`default_nettype none
module host_decode_irq_steering_glue_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import hdg_pkg::*;
    localparam int PC = 4;
    typedef struct {int k; logic [15:0] e;} hdg_note_t;
    logic ref_clk_i, rstn_i, aen_i, disk_en_i, gp_en_i, game_en_i, irq_route_en_i, epp_mode_i;
    logic ecp_mode_i, epp_busy_i, alt_fdc_mode_i, ext_irq_in_i, power_good_in_i, ring_ind_n_i;
    logic second_drive_sense_i, ser_irq_i, disk_if_enable_n_o, disk_ctrl_block_sel_n_o;
    logic disk_alt_status_sel_n_o, gp_block_decode_n_o, gp_block_decode_oe_n_o, ser_irq_o;
    logic game_port_sel_n_o, iochrdy_o, iochrdy_oe_n_o, outputs_float_o, second_drive_stat_n_o;
    logic ring_ind_n_o, chrdy_line, gp_line;
    logic [ADDR_W-1:0] sa_i, disk_base_i, gp_base_i, game_base_i;
    logic [1:0] gp_size_i;
    logic [2:0] irq_sel_i;
    logic [7:0] irq_o, irq_oe_n_o, irq_line, cap;
    int failures = 0, compares = 0, i, cnt;
    integer seed = 35308;
    hdg_note_t notes[$];
    hdg_note_t n;
    logic [4:0] dec_seen;
    // Decode pins gathered in the order the expectation is built
    assign dec_seen = {disk_if_enable_n_o, disk_ctrl_block_sel_n_o, disk_alt_status_sel_n_o,
                       gp_line, game_port_sel_n_o};

    hdg_glue #(.PULSE_CYC(PC)) u_hdg_glue (.ref_clk_i, .rstn_i, .sa_i, .aen_i, .disk_en_i,
        .disk_base_i, .gp_base_i, .gp_size_i, .gp_en_i, .game_base_i, .game_en_i, .irq_sel_i,
        .irq_route_en_i, .epp_mode_i, .ecp_mode_i, .epp_busy_i, .alt_fdc_mode_i, .ext_irq_in_i,
        .power_good_in_i, .second_drive_sense_i, .ring_ind_n_i, .ser_irq_i, .disk_if_enable_n_o,
        .disk_ctrl_block_sel_n_o, .disk_alt_status_sel_n_o, .gp_block_decode_n_o,
        .gp_block_decode_oe_n_o, .game_port_sel_n_o, .irq_o, .irq_oe_n_o, .iochrdy_o,
        .iochrdy_oe_n_o, .outputs_float_o, .second_drive_stat_n_o, .ring_ind_n_o, .ser_irq_o);
    hdg_host_model u_hdg_host_model (.irq_i(irq_o), .irq_oe_n_i(irq_oe_n_o), .chrdy_i(iochrdy_o),
        .chrdy_oe_n_i(iochrdy_oe_n_o), .gp_i(gp_block_decode_n_o),
        .gp_oe_n_i(gp_block_decode_oe_n_o), .irq_line_o(irq_line), .chrdy_line_o(chrdy_line),
        .gp_line_o(gp_line));

    // Clock at 25 MHz
    initial
    begin
        ref_clk_i = 0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(string what, logic [15:0] s, logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Note is compared at the next falling edge, inputs are held meanwhile
    task automatic note(int k, logic [15:0] e);
        notes.push_back('{k, e});
        @(negedge ref_clk_i);
    endtask

    // Decode expectation from the live address and configuration
    function automatic logic [4:0] exp_dec();
        logic d, g;
        logic [9:0] m;
        m = (gp_size_i == 2'h1) ? 10'h3F8 : (gp_size_i == 2'h2) ? 10'h3F0 : 10'h3FF;
        d = disk_en_i && !aen_i && sa_i[9:3] == disk_base_i[9:3] && sa_i != 10'h377
            && sa_i != 10'h3F7;
        g = gp_en_i && !aen_i && (sa_i & m) == (gp_base_i & m);
        return {!d, !d, !(d && sa_i == (disk_base_i | 10'h006)), !g,
                !(game_en_i && !aen_i && sa_i == game_base_i)};
    endfunction

    task automatic dec(int j);
        logic [9:0] b;
        b = (j % 3 == 0) ? (j[4] ? 10'h3F0 : 10'h370) : (j % 3 == 1) ? gp_base_i : game_base_i;
        @(posedge ref_clk_i);
        disk_base_i <= j[4] ? 10'h3F0 : 10'h370;
        gp_size_i <= 2'(j >> 5);
        sa_i <= (j % 16 == 15) ? b + 10'h007 : b + 10'($random(seed) & 31) - 10'h008;
        aen_i <= ($random(seed) & 7) == 0;
        {disk_en_i, gp_en_i, game_en_i} <= 3'($random(seed)) | 3'($random(seed));
        @(posedge ref_clk_i);
        note(0, {11'h000, exp_dec()});
    endtask

    // Monitor: oldest note against what the outputs show now
    always @(negedge ref_clk_i)
        if (notes.size() > 0)
        begin
            n = notes.pop_front();
            case (n.k)
                0: check("decode", 16'(dec_seen), n.e);
                1: check("irq", {irq_oe_n_o, irq_line}, n.e);
                2: check("chrdy", {iochrdy_oe_n_o, chrdy_line}, n.e);
                3: check("float", outputs_float_o, n.e);
                4: check("second drive", 16'(second_drive_stat_n_o), n.e);
                5: check("ring", {ring_ind_n_o, ser_irq_o}, n.e);
                default: check("pulse", {cnt[7:0], cap}, n.e);
            endcase
        end

    // Watchdog well past the expected run length
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        conclude();
    end

    initial
    begin
        {rstn_i, aen_i, disk_en_i, gp_en_i, game_en_i, epp_mode_i, ecp_mode_i} = 0;
        {epp_busy_i, alt_fdc_mode_i, ext_irq_in_i, ser_irq_i, second_drive_sense_i} = 0;
        {irq_route_en_i, power_good_in_i, ring_ind_n_i} = 3'h7;
        {sa_i, disk_base_i, gp_size_i, irq_sel_i} = 0;
        gp_base_i = 10'h2A0;
        game_base_i = 10'h201;
        // Outputs must be floated and drive status inactive while reset holds
        @(posedge ref_clk_i);
        notes.push_back('{4, 16'h0001});
        note(3, 16'h0001);
        @(posedge ref_clk_i);
        rstn_i <= 1;
        repeat (8) @(posedge ref_clk_i);
        for (i = 0; i < 240; i++) dec(i);
        $display("decode test done");
        // Steering: first half level mode, second half shared pulse mode
        for (i = 0; i < 16; i++)
        begin
            @(posedge ref_clk_i);
            irq_sel_i <= 3'(i);
            {epp_mode_i, ecp_mode_i} <= i[3] ? (i[0] ? 2'h2 : 2'h1) : 2'h0;
            ext_irq_in_i <= 1;
            if (!i[3])
            begin
                repeat (6) @(posedge ref_clk_i);
                note(1, {~(8'h01 << i[2:0]), 8'hFF});
            end
            else
            begin
                for (cnt = 0; cnt < 20 && irq_oe_n_o[i[2:0]]; cnt++) @(negedge ref_clk_i);
                cap = irq_line;
                for (cnt = 0; cnt < 20 && !irq_oe_n_o[i[2:0]]; cnt++) @(negedge ref_clk_i);
                @(posedge ref_clk_i);
                note(6, {8'(PC), ~(8'h01 << i[2:0])});
                note(1, 16'hFFFF);
            end
            @(posedge ref_clk_i);
            ext_irq_in_i <= 0;
            repeat (6) @(posedge ref_clk_i);
            // Level mode must follow the request down on the selected line
            if (!i[3])
                note(1, {~(8'h01 << i[2:0]), ~(8'h01 << i[2:0])});
        end
        $display("irq test done");
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk_i);
            {epp_mode_i, epp_busy_i} <= 2'(i);
            @(posedge ref_clk_i);
            note(2, (i == 3) ? 16'h0000 : 16'h0003);
        end
        $display("chrdy test done");
        @(posedge ref_clk_i);
        {epp_mode_i, epp_busy_i, power_good_in_i, sa_i, aen_i} <= {3'h0, disk_base_i, 1'b0};
        {disk_en_i, ext_irq_in_i, ring_ind_n_i, ser_irq_i} <= 4'hD;
        for (cnt = 0; cnt < 20 && !outputs_float_o; cnt++) @(posedge ref_clk_i);
        repeat (6) @(posedge ref_clk_i);
        note(3, 16'h0001);
        note(0, 16'h001F);
        note(1, 16'hFFFF);
        note(5, 16'h0001);
        @(posedge ref_clk_i);
        {power_good_in_i, ext_irq_in_i} <= 2'h2;
        for (cnt = 0; cnt < 20 && outputs_float_o; cnt++) @(posedge ref_clk_i);
        note(3, 16'h0000);
        $display("standby test done");
        // Drive sense taken in alternate mode only, held otherwise
        for (i = 0; i < 3; i++)
        begin
            @(posedge ref_clk_i);
            {alt_fdc_mode_i, second_drive_sense_i} <= {i < 2, i == 1};
            repeat (8) @(posedge ref_clk_i);
            note(4, 16'(i != 0));
        end
        $display("drive sense test done");
        // Let the monitor take the last note before the run ends
        @(posedge ref_clk_i);
        conclude();
    end
endmodule
`default_nettype wire
